// ===== pkg/tsc_pkg.sv
`default_nettype none
package tsc_pkg;
    // clock rate
    localparam int CLK_KHZ          = 40000;
    // timing figures in their own units
    localparam int POR_TIME_US      = 1000;
    localparam int CONV_TIME_MS     = 14;
    localparam int TIMEOUT_MIN_MS   = 15;
    localparam int TIMEOUT_MAX_MS   = 45;
    localparam int TIMEOUT_MS       = 30;
    // derived cycle counts
    localparam int POR_CYCLES       = (POR_TIME_US * CLK_KHZ) / 1000;
    localparam int CONV_CYCLES      = CONV_TIME_MS * CLK_KHZ;
    localparam int TIMEOUT_CYCLES   = TIMEOUT_MS * CLK_KHZ;
    localparam int TIMEOUT_MIN_CYC  = TIMEOUT_MIN_MS * CLK_KHZ;
    localparam int TIMEOUT_MAX_CYC  = TIMEOUT_MAX_MS * CLK_KHZ;
    localparam int CNT_W            = 24;
    // register byte offsets
    localparam logic [7:0] ADDR_TEMP     = 8'h00;
    localparam logic [7:0] ADDR_CONFIG   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQSTAT  = 8'h0c;
    localparam logic [7:0] ADDR_IRQMASK  = 8'h10;
    localparam logic [7:0] ADDR_POINTER  = 8'h14;
    // config fields
    localparam int CFG_SHUTDOWN     = 0;
    localparam int CFG_ONESHOT      = 1;
    localparam int CFG_RES_LOW      = 2;
    localparam int CFG_RES_HIGH     = 3;
    localparam int CFG_TIMEOUT_EN   = 4;
    // status fields
    localparam int ST_DAV           = 0;
    localparam int ST_BUSY          = 1;
    localparam int ST_READY         = 2;
    // interrupt fields
    localparam int IRQ_CONV_DONE    = 0;
    localparam int IRQ_BUS_TIMEOUT  = 1;
    localparam int IRQ_W            = 2;
    // reset values, one-shot temperature and resolution mask
    localparam logic        RST_SHUTDOWN   = 1'b0;
    localparam logic [1:0]  RST_RES        = 2'b00;
    localparam logic        RST_TIMEOUT_EN = 1'b1;
    localparam logic [15:0] RST_TEMP       = 16'h0000;
    localparam logic [15:0] ONESHOT_TEMP   = 16'h8000;
    localparam logic [2:0]  RST_POINTER    = 3'h0;
    localparam logic [15:0] RES_LSB_MASK   = 16'h001f;
    // serial bits per byte
    localparam logic [3:0]  BITS_PER_BYTE  = 4'd8;

    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_BITS = 2'b01,
        SER_ACK  = 2'b11,
        SER_WAIT = 2'b10
    } tsc_ser_t;
endpackage
`default_nettype wire

// ===== src/tsc_conv_engine.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_engine #(
    parameter int BASE_CYCLES = tsc_pkg::CONV_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic [1:0]  res,
    input  wire logic [15:0] sample,
    output logic             busy,
    output logic             done,
    output logic [15:0]      result
);
    logic [tsc_pkg::CNT_W-1:0] cnt;

    if (BASE_CYCLES < 1 || (BASE_CYCLES * 8) >= (1 << tsc_pkg::CNT_W)) begin : g_chk
        $error("conversion base count out of range");
    end

    // keep only the bits the chosen word size holds
    function automatic logic [15:0] resMask(input logic [1:0] r);
        resMask = ~(tsc_pkg::RES_LSB_MASK >> r);
    endfunction

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt    <= '0;
            busy   <= 1'b0;
            done   <= 1'b0;
            result <= tsc_pkg::RST_TEMP;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy && start) begin
                // time doubles with each resolution step
                cnt  <= tsc_pkg::CNT_W'((BASE_CYCLES << res) - 1); // [RQ15]
                busy <= 1'b1;
            end else if (busy) begin
                if (cnt == '0) begin
                    busy   <= 1'b0;
                    done   <= 1'b1;
                    result <= sample & resMask(res); // [RQ16] [RQ14]
                end else begin
                    cnt <= cnt - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/tsc_conv_control.sv
// Operation
// RQ1 - bus held low too long: idle, release
// RQ2 - host clock at most 400 kHz
// RQ3 - serial interface works within 1 ms
// RQ4 - valid temperature one conversion after ready
// RQ5 - registers hold defaults until changed
// RQ6 - first conversion updates temperature and status
// RQ7 - host writes replace read/write defaults
// RQ8 - shutdown halts conversions, registers stay reachable
// RQ9 - one-shot in shutdown runs one conversion
// RQ10 - pending one-shot: flag 0, temp 8000h
// RQ11 - other registers untouched during one-shot
// RQ12 - one-shot end: flag set, temperature loaded
// RQ13 - resolution programmable by host
// RQ14 - two-bit field selects 11 to 14 bits
// RQ15 - conversion time doubles per step
// RQ16 - left-justified two's complement, low bits zero
// RQ17 - pointer resets to temperature register
// RQ18 - one-shot self-clears, ignored when continuous
// RQ19 - timeout counter restarts when lines high
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_control #(
    parameter int POR_CYCLES     = tsc_pkg::POR_CYCLES,
    parameter int CONV_CYCLES    = tsc_pkg::CONV_CYCLES,
    parameter int TIMEOUT_CYCLES = tsc_pkg::TIMEOUT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic [15:0] tempSample
);
    if (POR_CYCLES < 1 || POR_CYCLES >= (1 << tsc_pkg::CNT_W)) begin : g_chk_por
        $error("power-on count out of range");
    end
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << tsc_pkg::CNT_W)) begin : g_chk_to
        $error("timeout count out of range");
    end

    logic                      sclMeta;
    logic                      sclSync;
    logic                      sdaMeta;
    logic                      sdaSync;
    logic                      sclPrev;
    logic                      sdaPrev;
    logic [tsc_pkg::CNT_W-1:0] porCnt;
    logic                      porReady;
    logic                      shutdown;
    logic                      oneShot;
    logic                      data_available_flag;
    logic                      resolution_select_high;
    logic                      resolution_select_low;
    logic                      timeoutEn;
    logic [15:0]               temp;
    logic [2:0]                pointer;
    logic [tsc_pkg::IRQ_W-1:0] irqStat;
    logic [tsc_pkg::IRQ_W-1:0] irqMask;
    logic [tsc_pkg::CNT_W-1:0] toCnt;
    logic                      busTimeout;
    tsc_pkg::tsc_ser_t         serState;
    logic [3:0]                bitCnt;
    logic                      convBusy;
    logic                      convDone;
    logic [15:0]               convResult;
    logic                      convStart;
    logic                      access;
    logic                      wrEn;
    logic                      oneShotTake;
    logic                      sclRise;
    logic                      sclFall;
    logic                      startCond;
    logic                      stopCond;
    logic [31:0]               next_prdata;
    logic                      next_slverr;
    logic [tsc_pkg::IRQ_W-1:0] irqEvent;

    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a == tsc_pkg::ADDR_TEMP) || (a == tsc_pkg::ADDR_CONFIG)
                || (a == tsc_pkg::ADDR_STATUS) || (a == tsc_pkg::ADDR_IRQSTAT)
                || (a == tsc_pkg::ADDR_IRQMASK) || (a == tsc_pkg::ADDR_POINTER);
    endfunction

    // first access edge raises ready; writes land at the completing edge
    assign access = psel && penable && !pready;
    assign wrEn   = psel && penable && pready && pwrite && isMapped(paddr);
    // one-shot accepted only when the written config keeps shutdown
    assign oneShotTake = wrEn && (paddr == tsc_pkg::ADDR_CONFIG)
                       && pwdata[tsc_pkg::CFG_ONESHOT]
                       && pwdata[tsc_pkg::CFG_SHUTDOWN]; // [RQ18] [RQ9]
    // continuous when running, single when one-shot pending
    assign convStart = porReady && !convBusy && !convDone
                     && (!shutdown || oneShot); // [RQ8] [RQ4]

    // line edges after synchronisation
    assign sclRise   = sclSync && !sclPrev;
    assign sclFall   = !sclSync && sclPrev;
    assign startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
    assign stopCond  = sclSync && sclPrev && !sdaPrev && sdaSync;
    assign irqEvent  = {busTimeout, convDone};

    tsc_conv_engine #(
        .BASE_CYCLES(CONV_CYCLES)
    ) u_engine (
        .clk_sys(clk_sys),
        .resetn (resetn),
        .ce     (ce),
        .start  (convStart),
        .res    ({resolution_select_high, resolution_select_low}), // [RQ13]
        .sample (tempSample),
        .busy   (convBusy),
        .done   (convDone),
        .result (convResult)
    );

    // two-stage synchronisers for the serial lines
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (ce) begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
        end
    end

    // power-on delay before the interface answers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            porCnt   <= '0;
            porReady <= 1'b0;
        end else if (ce && !porReady) begin
            if (porCnt == tsc_pkg::CNT_W'(POR_CYCLES - 1)) begin
                porReady <= 1'b1; // [RQ3]
            end else begin
                porCnt <= porCnt + 1'b1;
            end
        end
    end

    // configuration register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shutdown               <= tsc_pkg::RST_SHUTDOWN; // [RQ5]
            resolution_select_high <= tsc_pkg::RST_RES[1];
            resolution_select_low  <= tsc_pkg::RST_RES[0];
            timeoutEn              <= tsc_pkg::RST_TIMEOUT_EN;
            oneShot                <= 1'b0;
        end else if (ce) begin
            if (wrEn && paddr == tsc_pkg::ADDR_CONFIG) begin
                shutdown               <= pwdata[tsc_pkg::CFG_SHUTDOWN]; // [RQ7] [RQ8]
                resolution_select_high <= pwdata[tsc_pkg::CFG_RES_HIGH]; // [RQ14]
                resolution_select_low  <= pwdata[tsc_pkg::CFG_RES_LOW];
                timeoutEn              <= pwdata[tsc_pkg::CFG_TIMEOUT_EN]; // [RQ2]
            end
            if (oneShotTake) begin
                oneShot <= 1'b1; // [RQ9]
            end else if (oneShot && convDone) begin
                oneShot <= 1'b0; // [RQ18]
            end
        end
    end

    // temperature register and data-available flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            temp                <= tsc_pkg::RST_TEMP; // [RQ5]
            data_available_flag <= 1'b0;
        end else if (ce) begin
            if (convDone) begin
                temp                <= convResult; // [RQ6] [RQ12]
                data_available_flag <= 1'b1; // [RQ12]
            end else if (oneShotTake && !oneShot) begin
                temp                <= tsc_pkg::ONESHOT_TEMP; // [RQ10]
                data_available_flag <= 1'b0; // [RQ10] [RQ11]
            end
        end
    end

    // pointer register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pointer <= tsc_pkg::RST_POINTER; // [RQ17]
        end else if (ce && wrEn && paddr == tsc_pkg::ADDR_POINTER) begin
            pointer <= pwdata[2:0]; // [RQ7]
        end
    end

    // interrupt status, set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqStat <= '0;
            irqMask <= '0;
            irq     <= 1'b0;
        end else if (ce) begin
            if (wrEn && paddr == tsc_pkg::ADDR_IRQSTAT) begin
                irqStat <= (irqStat & ~pwdata[tsc_pkg::IRQ_W-1:0]) | irqEvent;
            end else begin
                irqStat <= irqStat | irqEvent;
            end
            if (wrEn && paddr == tsc_pkg::ADDR_IRQMASK) begin
                irqMask <= pwdata[tsc_pkg::IRQ_W-1:0];
            end
            irq <= |(irqStat & irqMask);
        end
    end

    // bus timeout counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            toCnt      <= '0;
            busTimeout <= 1'b0;
        end else if (ce) begin
            busTimeout <= 1'b0;
            if ((sclSync && sdaSync) || !timeoutEn) begin
                toCnt <= '0; // [RQ19]
            end else if (toCnt == tsc_pkg::CNT_W'(TIMEOUT_CYCLES - 1)) begin
                toCnt      <= '0;
                busTimeout <= 1'b1; // [RQ1] [RQ19]
            end else begin
                toCnt <= toCnt + 1'b1;
            end
        end
    end

    // serial state machine: acknowledges each byte after start
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serState <= tsc_pkg::SER_IDLE;
            bitCnt   <= '0;
            sdaOe    <= 1'b0;
            sdaOut   <= 1'b0;
        end else if (ce) begin
            sdaOut <= 1'b0;
            if (busTimeout || !porReady) begin
                serState <= tsc_pkg::SER_IDLE; // [RQ1] [RQ3]
                sdaOe    <= 1'b0;
                bitCnt   <= '0;
            end else if (stopCond) begin
                serState <= tsc_pkg::SER_IDLE;
                sdaOe    <= 1'b0;
            end else if (startCond) begin
                serState <= tsc_pkg::SER_BITS;
                sdaOe    <= 1'b0;
                bitCnt   <= '0;
            end else begin
                case (serState)
                    tsc_pkg::SER_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    tsc_pkg::SER_BITS: begin
                        if (sclRise) begin
                            bitCnt <= bitCnt + 1'b1;
                        end
                        if (sclFall && bitCnt == tsc_pkg::BITS_PER_BYTE) begin
                            serState <= tsc_pkg::SER_ACK;
                            sdaOe    <= 1'b1;
                        end
                    end
                    tsc_pkg::SER_ACK: begin
                        if (sclRise) begin
                            serState <= tsc_pkg::SER_WAIT;
                        end
                    end
                    tsc_pkg::SER_WAIT: begin
                        if (sclFall) begin
                            serState <= tsc_pkg::SER_BITS;
                            sdaOe    <= 1'b0;
                            bitCnt   <= '0;
                        end
                    end
                    default: begin
                        serState <= tsc_pkg::SER_IDLE;
                        sdaOe    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // read mux
    always_comb begin
        next_prdata = '0;
        next_slverr = !isMapped(paddr);
        case (paddr)
            tsc_pkg::ADDR_TEMP: begin
                next_prdata[15:0] = temp; // [RQ16]
            end
            tsc_pkg::ADDR_CONFIG: begin
                next_prdata[tsc_pkg::CFG_SHUTDOWN]   = shutdown;
                next_prdata[tsc_pkg::CFG_ONESHOT]    = oneShot;
                next_prdata[tsc_pkg::CFG_RES_LOW]    = resolution_select_low;
                next_prdata[tsc_pkg::CFG_RES_HIGH]   = resolution_select_high;
                next_prdata[tsc_pkg::CFG_TIMEOUT_EN] = timeoutEn;
            end
            tsc_pkg::ADDR_STATUS: begin
                next_prdata[tsc_pkg::ST_DAV]   = data_available_flag;
                next_prdata[tsc_pkg::ST_BUSY]  = convBusy;
                next_prdata[tsc_pkg::ST_READY] = porReady;
            end
            tsc_pkg::ADDR_IRQSTAT: begin
                next_prdata[tsc_pkg::IRQ_W-1:0] = irqStat;
            end
            tsc_pkg::ADDR_IRQMASK: begin
                next_prdata[tsc_pkg::IRQ_W-1:0] = irqMask;
            end
            tsc_pkg::ADDR_POINTER: begin
                next_prdata[2:0] = pointer;
            end
            default: begin
                next_prdata = '0;
            end
        endcase
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready  <= access;
            pslverr <= access && next_slverr;
            if (access && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tsc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_checker #(
    parameter int POR_CYCLES     = tsc_pkg::POR_CYCLES,
    parameter int TIMEOUT_CYCLES = tsc_pkg::TIMEOUT_CYCLES
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe
);
    int porCnt;
    int lowCnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // cycles since reset release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            porCnt <= 0;
        end else if (porCnt < POR_CYCLES) begin
            porCnt <= porCnt + 1;
        end
    end
    // cycles with either serial line low
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lowCnt <= 0;
        end else begin
            lowCnt <= (sclIn && sdaIn) ? 0 : lowCnt + 1;
        end
    end
    ready_after_access_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("error outside ready");
    read_hold_a: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without read");
    irq_fall_a: assert property ($fell(irq) |-> $past(pwrite && penable) || $past(pwrite, 2))
        else $error("interrupt dropped without write");
    open_drain_a: assert property (sdaOut == 1'b0)
        else $error("data output driven high");
    ack_low_clock_a: assert property ($rose(sdaOe) |-> !sclIn)
        else $error("ack started outside low clock");
    por_quiet_a: assert property (porCnt < POR_CYCLES |-> !sdaOe)
        else $error("ack before interface ready");
    bus_timeout_a: assert property (lowCnt > TIMEOUT_CYCLES + 8 |-> !sdaOe)
        else $error("data line held after bus timeout");
endmodule
bind tsc_conv_control tsc_checker #(
    .POR_CYCLES(POR_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) i_checker (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe)
);
`default_nettype wire

// ===== testbench/tsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model (
    input  wire logic clk_sys,
    input  wire logic sdaLine,
    output logic      scl,
    output logic      sdaLow
);
    int acks = 0;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // half of a 200 ns serial period
    task automatic half();
        repeat (4) @(posedge clk_sys);
    endtask
    // start, one byte, ack clock, stop; stall holds the clock low at the ack
    task automatic frame(input logic [7:0] b, input int stall);
        sdaLow <= 1'b1;
        half();
        scl <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdaLow <= ~b[i];
            half();
            scl <= 1'b1;
            half();
            scl <= 1'b0;
        end
        sdaLow <= 1'b0;
        repeat (stall) @(posedge clk_sys);
        half();
        scl <= 1'b1;
        half();
        if (sdaLine === 1'b0) begin
            acks++;
        end
        scl <= 1'b0;
        sdaLow <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sdaLow <= 1'b0;
        half();
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_temp_sensor_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_conversion_control;
    localparam int          POR = 20;
    localparam int          CONV = 50;
    localparam int          TMO = 100;
    localparam int          AVAIL_BIT = 0; // data available flag
    localparam logic [31:0] SHDN = 32'h1 << tsc_pkg::CFG_SHUTDOWN;
    localparam logic [31:0] ONE = 32'h1 << tsc_pkg::CFG_ONESHOT;
    localparam logic [31:0] TEN = 32'h1 << tsc_pkg::CFG_TIMEOUT_EN;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] tempSample = 16'hc9f7;
    logic        ce = 1'b1;
    logic [31:0] prdata, q, cfg;
    logic        pready, pslverr, irq, sdaOut, sdaOe, scl, sdaLow, err;
    wire         sdaLine;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          t0;
    int          tMin;
    assign sdaLine = !(sdaOe || sdaLow);
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;
    tsc_conv_control #(.POR_CYCLES(POR), .CONV_CYCLES(CONV), .TIMEOUT_CYCLES(TMO)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .tempSample(tempSample));
    tsc_host_model i_host (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
    function automatic logic [15:0] resMask(input int r);
        return 16'hffff << (5 - r);
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk_sys);
            n++;
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_word(q, exp);
    endtask
    // polls status until bit b reads v
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        apb(1'b0, tsc_pkg::ADDR_STATUS, 32'h0);
        while (q[b] !== v && n < 400) begin
            apb(1'b0, tsc_pkg::ADDR_STATUS, 32'h0);
            n++;
        end
        if (n >= 400) begin
            failures++;
            finish_test();
        end
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        t0 = cyc;
        rd_chk(tsc_pkg::ADDR_STATUS, 32'h0);
        rd_chk(tsc_pkg::ADDR_TEMP, 32'h0);
        rd_chk(tsc_pkg::ADDR_CONFIG, TEN);
        rd_chk(tsc_pkg::ADDR_POINTER, 32'h0);
        rd_chk(tsc_pkg::ADDR_IRQMASK, 32'h0);
        rd_chk(8'h18, 32'h0);
        chk_bit(err, 1'b1);
        apb(1'b1, tsc_pkg::ADDR_POINTER, 32'h5);
        chk_bit(err, 1'b0);
        rd_chk(tsc_pkg::ADDR_POINTER, 32'h5);
        apb(1'b1, tsc_pkg::ADDR_IRQMASK, 32'h1);
        wait_st(tsc_pkg::ST_READY, 1'b1);
        wait_st(AVAIL_BIT, 1'b1);
        chk_bit(cyc - t0 <= POR + CONV + 16, 1'b1);
        rd_chk(tsc_pkg::ADDR_TEMP, {16'h0, tempSample & resMask(0)});
        chk_bit(irq, 1'b1);
        i_host.frame(8'ha5, 0);
        chk_word(i_host.acks, 1);
        apb(1'b1, tsc_pkg::ADDR_CONFIG, TEN | SHDN);
        wait_st(tsc_pkg::ST_BUSY, 1'b0);
        apb(1'b1, tsc_pkg::ADDR_IRQSTAT, 32'h3);
        rd_chk(tsc_pkg::ADDR_IRQSTAT, 32'h0);
        chk_bit(irq, 1'b0);
        for (int r = 0; r < 4; r++) begin
            cfg = TEN | SHDN | (32'(r) << tsc_pkg::CFG_RES_LOW);
            t0 = cyc;
            apb(1'b1, tsc_pkg::ADDR_CONFIG, cfg | ONE);
            // first pass freezes the block for CONV cycles, stretching the conversion
            tMin = (CONV << r) + ((r == 0) ? CONV : 0);
            ce <= (r != 0);
            repeat (CONV) @(posedge clk_sys);
            ce <= 1'b1;
            rd_chk(tsc_pkg::ADDR_TEMP, 32'h8000);
            apb(1'b0, tsc_pkg::ADDR_STATUS, 32'h0);
            chk_bit(q[AVAIL_BIT], 1'b0);
            rd_chk(tsc_pkg::ADDR_POINTER, 32'h5);
            rd_chk(tsc_pkg::ADDR_IRQMASK, 32'h1);
            wait_st(AVAIL_BIT, 1'b1);
            chk_bit(cyc - t0 >= tMin && cyc - t0 <= tMin + 24, 1'b1);
            rd_chk(tsc_pkg::ADDR_TEMP, {16'h0, tempSample & resMask(r)});
            rd_chk(tsc_pkg::ADDR_CONFIG, cfg);
            chk_bit(irq, 1'b1);
            apb(1'b1, tsc_pkg::ADDR_IRQSTAT, 32'h1);
        end
        repeat (CONV * 16) @(posedge clk_sys);
        rd_chk(tsc_pkg::ADDR_IRQSTAT, 32'h0);
        apb(1'b1, tsc_pkg::ADDR_CONFIG, TEN | ONE);
        apb(1'b0, tsc_pkg::ADDR_TEMP, 32'h0);
        chk_bit(q === 32'h8000, 1'b0);
        rd_chk(tsc_pkg::ADDR_CONFIG, TEN);
        i_host.frame(8'ha5, TMO + 50);
        chk_word(i_host.acks, 1);
        apb(1'b0, tsc_pkg::ADDR_IRQSTAT, 32'h0);
        chk_bit(q[tsc_pkg::IRQ_BUS_TIMEOUT], 1'b1);
        i_host.frame(8'h3c, 0);
        chk_word(i_host.acks, 2);
        apb(1'b1, tsc_pkg::ADDR_IRQMASK, 32'h0);
        rd_chk(tsc_pkg::ADDR_IRQMASK, 32'h0);
        chk_bit(irq, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
